// ---- design/lrbs_regs.vh ----
/*
 Constants for the lite register bus slave: widths, response codes,
 strobe policies, register-file geometry and reset values.
 Assumes it is included once per design file by its bare name.
*/
`ifndef LRBS_REGS_VH
`define LRBS_REGS_VH

`define LRBS_DATA_W       64
`define LRBS_STRB_W       8
`define LRBS_ADDR_W       32
`define LRBS_ID_W         4
`define LRBS_PROT_W       3
`define LRBS_RESP_W       2
`define LRBS_BYTE_W       8
`define LRBS_WORD_LSB     3
`define LRBS_IDX_W        3
`define LRBS_NUM_WORDS    8
`define LRBS_DEC_MSB      11
`define LRBS_PROT_SEC     1

`define LRBS_RESP_OKAY    2'h0
`define LRBS_RESP_SLVERR  2'h2
`define LRBS_RESP_DECERR  2'h3

`define LRBS_POL_BYTE     2'h0
`define LRBS_POL_FULL     2'h1
`define LRBS_POL_ERR      2'h2

`define LRBS_REG_RST      64'h0000_0000_0000_0000
`define LRBS_ID_RST       4'h0
`define LRBS_STRB_ALL     8'hff
`define LRBS_STRB_NONE    8'h00
`define LRBS_STRB_LO32    8'h0f

`endif

// ---- design/lrbs_word.v ----
/*
 One storage word of the register file with per-byte write enables.
 Assumes the caller has already decided which lanes are to be written.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lrbs_regs.vh"

module lrbs_word (
   input  wire                      mclk,
   input  wire                      rst_n,
   input  wire [`LRBS_STRB_W-1:0]   lane_we,
   input  wire [`LRBS_DATA_W-1:0]   wdata,
   output wire [`LRBS_DATA_W-1:0]   q
);
   reg  [`LRBS_DATA_W-1:0] word_r;
   genvar                  b;
   // Reset word kept as a full-width constant so each lane takes its own slice
   localparam [`LRBS_DATA_W-1:0] RST_WORD = `LRBS_REG_RST;

   assign q = word_r;

   // Each byte lane keeps its old value unless enabled
   generate
      for (b = 0; b < `LRBS_STRB_W; b = b + 1) begin : g_lane
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               word_r[b*`LRBS_BYTE_W +: `LRBS_BYTE_W] <= RST_WORD[b*`LRBS_BYTE_W +: `LRBS_BYTE_W];
            end else if (lane_we[b]) begin
               word_r[b*`LRBS_BYTE_W +: `LRBS_BYTE_W] <= wdata[b*`LRBS_BYTE_W +: `LRBS_BYTE_W];
            end
         end
      end
   endgenerate
endmodule

`default_nettype wire

// ---- design/lrbs_slave.v ----
/*
 Lite register bus slave: single-beat reads and writes to a small
 register file of full-width words, with ID reflection and a selectable
 write strobe policy.
 Assumes a master on the same clock that keeps valid and payload stable
 until accepted and drives correct strobes.
*/
// Behaviour
// - Every transfer is one data beat
// - Data width fixed at 64 bits
// - Every read moves a full word; writes move the lanes the strobe policy enables
// - Cache attributes ignored, non-bufferable
// - Lock attributes ignored, normal access
// - No exclusive access, no exclusive-okay
// - Responses only okay, slave error, decode error
// - No last-beat signals on data channels
// - Outstanding limited by holding ready low
// - Responses return in request order
// - Read data never interleaved
// - One strobe policy: bytes, full, error
// - Byte policy writes only strobed lanes
// - Empty-strobe write completes with response; harmless except under full policy, which writes all lanes
// - 64-bit slave; 32-bit registers use low half
// - Captured address ID returned with response
// - Write response ID from write address
// - Direct full-bus link only within subset
// - Only the lite signal set is carried
// - Low address bits ignored, bits 11:6 zero, bits above 11 ignored
// - Secure flag from protection bit one
`timescale 1ns/10ps
`default_nettype none
`include "lrbs_regs.vh"

module lrbs_slave #(
   parameter [1:0] STRB_POLICY = `LRBS_POL_BYTE,
   parameter [0:0] SECURE_ONLY = 1'b0
) (
   input  wire                      mclk,
   input  wire                      rst_n,
   input  wire [`LRBS_ID_W-1:0]     awid,
   input  wire [`LRBS_ADDR_W-1:0]   awaddr,
   input  wire [`LRBS_PROT_W-1:0]   awprot,
   input  wire                      awvalid,
   output wire                      awready,
   input  wire [`LRBS_DATA_W-1:0]   wdata,
   input  wire [`LRBS_STRB_W-1:0]   wstrb,
   input  wire                      wvalid,
   output wire                      wready,
   output reg  [`LRBS_ID_W-1:0]     bid,
   output reg  [`LRBS_RESP_W-1:0]   bresp,
   output reg                       bvalid,
   input  wire                      bready,
   input  wire [`LRBS_ID_W-1:0]     arid,
   input  wire [`LRBS_ADDR_W-1:0]   araddr,
   input  wire [`LRBS_PROT_W-1:0]   arprot,
   input  wire                      arvalid,
   output wire                      arready,
   output reg  [`LRBS_ID_W-1:0]     rid,
   output reg  [`LRBS_DATA_W-1:0]   rdata,
   output reg  [`LRBS_RESP_W-1:0]   rresp,
   output reg                       rvalid,
   input  wire                      rready
);
   // Write address latch, filled ahead of the data if it comes first
   reg                       aw_full_r;
   reg  [`LRBS_ID_W-1:0]     aw_id_r;
   reg  [`LRBS_ADDR_W-1:0]   aw_addr_r;
   reg                       aw_sec_r;
   // Write data latch
   reg                       w_full_r;
   reg  [`LRBS_DATA_W-1:0]   w_data_r;
   reg  [`LRBS_STRB_W-1:0]   w_strb_r;

   wire                      aw_hs;
   wire                      w_hs;
   wire                      ar_hs;
   wire                      do_write;
   wire [`LRBS_IDX_W-1:0]    w_idx;
   wire [`LRBS_IDX_W-1:0]    r_idx;
   wire                      w_in_map;
   wire                      r_in_map;
   wire                      w_sec_ok;
   wire                      r_sec_ok;
   reg                       strb_ok;
   reg  [`LRBS_STRB_W-1:0]   lane_en;
   reg  [`LRBS_RESP_W-1:0]   w_resp;
   reg  [`LRBS_RESP_W-1:0]   r_resp;
   wire [`LRBS_DATA_W*`LRBS_NUM_WORDS-1:0] words;

   // Handshake: one write and one read in flight; more stalls on ready
   assign awready = !aw_full_r && !bvalid;
   assign wready  = !w_full_r && !bvalid;
   assign arready = !rvalid;
   assign aw_hs   = awvalid && awready;
   assign w_hs    = wvalid && wready;
   assign ar_hs   = arvalid && arready;

   // A write fires once both halves are held; each is a single beat
   assign do_write = aw_full_r && w_full_r && !bvalid;

   // Word index from the address; low lane bits are never looked at
   assign w_idx    = aw_addr_r[`LRBS_WORD_LSB +: `LRBS_IDX_W];
   assign r_idx    = araddr[`LRBS_WORD_LSB +: `LRBS_IDX_W];
   assign w_in_map = (aw_addr_r[`LRBS_DEC_MSB:`LRBS_WORD_LSB+`LRBS_IDX_W] == 0);
   assign r_in_map = (araddr[`LRBS_DEC_MSB:`LRBS_WORD_LSB+`LRBS_IDX_W] == 0);

   // Security is bit one of the protection field, low meaning secure
   assign w_sec_ok = !SECURE_ONLY || aw_sec_r;
   assign r_sec_ok = !SECURE_ONLY || !arprot[`LRBS_PROT_SEC];

   // Strobe policy decides lane enables and whether the pattern is legal
   always @* begin
      strb_ok = 1'b1;
      lane_en = `LRBS_STRB_NONE;
      case (STRB_POLICY)
         `LRBS_POL_FULL: begin
            lane_en = `LRBS_STRB_ALL;
         end
         `LRBS_POL_ERR: begin
            // Only full word, low half or no lanes at all are accepted
            strb_ok = (w_strb_r == `LRBS_STRB_ALL) || (w_strb_r == `LRBS_STRB_LO32) ||
                      (w_strb_r == `LRBS_STRB_NONE);
            lane_en = strb_ok ? w_strb_r : `LRBS_STRB_NONE;
         end
         default: begin
            lane_en = w_strb_r;
         end
      endcase
   end

   // Write response code; exclusive-okay is never produced
   always @* begin
      if (!w_in_map) begin
         w_resp = `LRBS_RESP_DECERR;
      end else if (!w_sec_ok || !strb_ok) begin
         w_resp = `LRBS_RESP_SLVERR;
      end else begin
         w_resp = `LRBS_RESP_OKAY;
      end
   end

   // Read response code
   always @* begin
      if (!r_in_map) begin
         r_resp = `LRBS_RESP_DECERR;
      end else if (!r_sec_ok) begin
         r_resp = `LRBS_RESP_SLVERR;
      end else begin
         r_resp = `LRBS_RESP_OKAY;
      end
   end

   // Register file: full 64-bit words, byte-enabled; cache and lock are unused
   genvar i;
   generate
      for (i = 0; i < `LRBS_NUM_WORDS; i = i + 1) begin : g_word
         wire [`LRBS_STRB_W-1:0] we;
         assign we = (do_write && w_resp == `LRBS_RESP_OKAY && w_idx == i) ?
                     lane_en : `LRBS_STRB_NONE;
         lrbs_word u_word (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .lane_we (we),
            .wdata   (w_data_r),
            .q       (words[i*`LRBS_DATA_W +: `LRBS_DATA_W])
         );
      end
   endgenerate

   // Address and data latches; reset drops half-taken writes
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_r <= 1'b0;
         aw_id_r   <= `LRBS_ID_RST;
         aw_addr_r <= {`LRBS_ADDR_W{1'b0}};
         aw_sec_r  <= 1'b0;
         w_full_r  <= 1'b0;
         w_data_r  <= `LRBS_REG_RST;
         w_strb_r  <= `LRBS_STRB_NONE;
      end else begin
         if (aw_hs) begin
            aw_full_r <= 1'b1;
            aw_id_r   <= awid;
            aw_addr_r <= awaddr;
            aw_sec_r  <= !awprot[`LRBS_PROT_SEC];
         end else if (do_write) begin
            aw_full_r <= 1'b0;
         end
         if (w_hs) begin
            w_full_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end else if (do_write) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // Write response channel, held until the master takes it
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp  <= `LRBS_RESP_OKAY;
         bid    <= `LRBS_ID_RST;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= w_resp;
         bid    <= aw_id_r;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read data channel; one beat per request, so nothing interleaves
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rresp  <= `LRBS_RESP_OKAY;
         rid    <= `LRBS_ID_RST;
         rdata  <= `LRBS_REG_RST;
      end else if (ar_hs) begin
         rvalid <= 1'b1;
         rresp  <= r_resp;
         rid    <= arid;
         // Errored reads return zero rather than leak a word
         rdata  <= (r_resp == `LRBS_RESP_OKAY) ?
                   words[r_idx*`LRBS_DATA_W +: `LRBS_DATA_W] : `LRBS_REG_RST;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// ---- verification/lrbs_props.sv ----
/*
 Port assertions for the register bus slave.
 Assumes one clock and binding onto every lrbs_slave instance.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lrbs_regs.vh"
module lrbs_props (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire logic [`LRBS_ID_W-1:0]   awid,
   input wire logic                    awvalid,
   input wire logic                    awready,
   input wire logic                    wvalid,
   input wire logic                    wready,
   input wire logic [`LRBS_ID_W-1:0]   bid,
   input wire logic [1:0]              bresp,
   input wire logic                    bvalid,
   input wire logic                    bready,
   input wire logic [`LRBS_ID_W-1:0]   arid,
   input wire logic [31:0]             araddr,
   input wire logic                    arvalid,
   input wire logic                    arready,
   input wire logic [`LRBS_ID_W-1:0]   rid,
   input wire logic [63:0]             rdata,
   input wire logic [1:0]              rresp,
   input wire logic                    rvalid,
   input wire logic                    rready
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Exclusive-okay must never leave the slave
   a_bresp_no_exok: assert property (bvalid |-> bresp != 2'h1)
      else $error("write response carries exclusive okay");
   a_rresp_no_exok: assert property (rvalid |-> rresp != 2'h1)
      else $error("read response carries exclusive okay");
   // Responses stand unchanged until taken
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable({bid, bresp}))
      else $error("write response dropped or changed before taken");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rid, rresp, rdata}))
      else $error("read response dropped or changed before taken");
   a_read_id_echo: assert property (arvalid && arready |=> rvalid && rid == $past(arid))
      else $error("read answer late or wrong id");
   a_write_id_echo: assert property (awvalid && awready && wvalid && wready |=> ##1
      bvalid && bid == $past(awid, 2))
      else $error("write answer late or id not from address");
   a_ready_throttle: assert property (bvalid |-> !awready && !wready)
      else $error("new write taken while a write response is pending");
   a_read_throttle: assert property (rvalid |-> !arready)
      else $error("new read taken while read data is pending");
   a_decode_error: assert property (arvalid && arready && araddr[11:6] != 6'h0 |=>
      rresp == `LRBS_RESP_DECERR && rdata == 64'h0)
      else $error("out of window read not refused");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !bvalid && !rvalid)
      else $error("response valid high in reset");
endmodule
bind lrbs_slave lrbs_props lrbs_props_i (.mclk, .rst_n, .awid, .awvalid, .awready, .wvalid,
   .wready, .bid, .bresp, .bvalid, .bready, .arid, .araddr, .arvalid, .arready, .rid, .rdata,
   .rresp, .rvalid, .rready);
`default_nettype wire

// ---- verification/lrbs_bfm.sv ----
/*
 Master model driving the address and write data channels.
 Assumes the bench drives the response ready signals itself.
*/
`timescale 1ns/10ps
`default_nettype none
module lrbs_bfm (
   input  wire logic        mclk,
   output var  logic [3:0]  awid,
   output var  logic [31:0] awaddr,
   output var  logic [2:0]  awprot,
   output var  logic        awvalid,
   input  wire logic        awready,
   output var  logic [63:0] wdata,
   output var  logic [7:0]  wstrb,
   output var  logic        wvalid,
   input  wire logic        wready,
   output var  logic [3:0]  arid,
   output var  logic [31:0] araddr,
   output var  logic [2:0]  arprot,
   output var  logic        arvalid,
   input  wire logic        arready
);
   // Idle bus at time zero
   initial begin
      {awid, awaddr, awprot, awvalid, wdata, wstrb, wvalid} = '0;
      {arid, araddr, arprot, arvalid} = '0;
   end
   // Ready read at negedge: stable then, so no race with the edge
   task automatic write(input logic [3:0] id, input logic [31:0] a, input logic [63:0] d,
                        input logic [7:0] s);
      logic ad, wd, ta, tw;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge mclk);
      awid <= id; awaddr <= a; awprot <= id[2:0]; awvalid <= 1'b1;
      wdata <= d; wstrb <= s; wvalid <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge mclk);
         ta = awready;
         tw = wready;
         @(posedge mclk);
         if (ta && !ad) begin
            ad = 1'b1; awvalid <= 1'b0; awaddr <= ~a;
         end
         if (tw && !wd) begin
            wd = 1'b1; wvalid <= 1'b0; wdata <= ~d;
         end
      end
   endtask
   // Released address shows its inverse, never the stale value
   task automatic read(input logic [3:0] id, input logic [31:0] a);
      logic tr;
      tr = 1'b0;
      @(posedge mclk);
      arid <= id; araddr <= a; arprot <= id[2:0]; arvalid <= 1'b1;
      while (!tr) begin
         @(negedge mclk);
         tr = arready;
         @(posedge mclk);
      end
      arvalid <= 1'b0; araddr <= ~a;
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
/*
 Self-checking bench for the register bus slave, byte strobe policy.
 Assumes the master model and checker files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lrbs_regs.vh"
module tb_top;
   logic [3:0]  awid, arid, bid, rid, id;
   logic [31:0] awaddr, araddr, a;
   logic [2:0]  awprot, arprot;
   logic [63:0] wdata, rdata, d;
   logic [7:0]  wstrb, s;
   logic [1:0]  bresp, rresp, e;
   logic        mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [63:0] mem [0:7];
   logic [5:0]  wq [$];
   logic [69:0] rq [$];
   integer      seed, n_errors, checks, i, k;
   // Master model issues only single-beat subset accesses
   lrbs_bfm lrbs_bfm_i (.mclk, .awid, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .arid, .araddr, .arprot, .arvalid, .arready);
   lrbs_slave #(.STRB_POLICY(`LRBS_POL_BYTE)) lrbs_slave_i (.mclk, .rst_n, .awid, .awaddr,
      .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bid, .bresp, .bvalid,
      .bready, .arid, .araddr, .arprot, .arvalid, .arready, .rid, .rdata, .rresp, .rvalid,
      .rready);
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task cmp(input logic [69:0] got, input logic [69:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Expectation noted first; shadow words merge strobed lanes only
   task automatic wr(input logic [3:0] id, input logic [31:0] a, input logic [63:0] d,
                     input logic [7:0] s);
      logic bad;
      bad = a[11:6] != 6'h0;
      wq.push_back({id, bad ? `LRBS_RESP_DECERR : `LRBS_RESP_OKAY});
      for (int j = 0; j < 8; j++) if (!bad && s[j]) mem[a[5:3]][8*j+:8] = d[8*j+:8];
      lrbs_bfm_i.write(id, a, d, s);
   endtask
   task automatic rd(input logic [3:0] id, input logic [31:0] a);
      logic bad;
      bad = a[11:6] != 6'h0;
      rq.push_back({id, bad ? `LRBS_RESP_DECERR : `LRBS_RESP_OKAY, bad ? 64'h0 : mem[a[5:3]]});
      lrbs_bfm_i.read(id, a);
   endtask
   // Random stalls on the response channels, prompt and slow alike
   always @(posedge mclk) {bready, rready} <= 2'($random(seed));
   // Oldest note per channel against each taken response
   always @(posedge mclk) begin
      if (bvalid && bready) cmp({64'h0, bid, bresp}, {64'h0, wq.pop_front()});
      if (rvalid && rready) cmp({rid, rresp, rdata}, rq.pop_front());
   end
   // Generous bound: the whole run needs well under a thousand cycles
   initial begin
      #(40 * 10000);
      n_errors++;
      results;
   end
   // Main sequence
   initial begin
      seed = 32'hfdc3_66fb;
      n_errors = 0;
      checks = 0;
      rst_n = 1'b0;
      for (k = 0; k < 8; k++) mem[k] = `LRBS_REG_RST;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (k = 0; k < 8; k++) rd(4'(k), 32'(k * 8));
      $display("test reset_values done");
      for (i = 0; i < 80; i++) begin
         a = $random(seed) & 32'hffff_f07f;
         id = 4'($random(seed));
         d = {$random(seed), $random(seed)};
         e = 2'($random(seed));
         s = e[0] ? {8{e[1]}} : 8'($random(seed));
         if (e[1] ^ i[0]) wr(id, a, d, s);
         else rd(id, a);
      end
      $display("test random_traffic done");
      fork
         wr(4'h5, 32'h0000_0008, 64'h0123_4567_89ab_cdef, `LRBS_STRB_LO32);
         rd(4'ha, 32'h0000_0010);
      join
      rd(4'h3, 32'h0000_0008);
      k = 0;
      while ((wq.size() || rq.size()) && k < 200) begin
         @(posedge mclk);
         k++;
      end
      if (k == 200) n_errors++;
      $display("test overlap done");
      results;
   end
endmodule
`default_nettype wire
